// ### common/timer_mode_defines.svh
// Register numbers, field positions, reset values and rates of the interval timer block
`ifndef TIMER_MODE_DEFINES_SVH
`define TIMER_MODE_DEFINES_SVH

// Register numbers and select on the system coprocessor register port
`define REG_NUM_COUNTER 5'h09
`define REG_NUM_COMPARE 5'h0b
`define REG_NUM_PSTATUS 5'h0c
`define REG_SEL_MAIN 3'h0

// Processor status field positions
`define PS_SYSCOP_USABLE 28
`define PS_REDUCED_POWER 27
`define PS_REVERSE_ENDIAN 25
`define PS_BOOT_VECTOR 22
`define PS_SOFT_RESET 20
`define PS_NMI_FLAG 19
`define PS_PRIO_LSB 10
`define PS_PRIO_MSB 12
`define PS_USER_MODE 4
`define PS_ERROR_LEVEL 2
`define PS_EXC_LEVEL 1
`define PS_GLOBAL_IE 0

// Reset values; counter and compare are undefined after reset, zero is chosen
`define COUNTER_RESET 32'h0000_0000
`define COMPARE_RESET 32'h0000_0000
`define PS_BOOT_VECTOR_RESET 1'b1
`define PS_SOFT_RESET_RESET 1'b1
`define PS_NMI_RESET 1'b0
`define PS_REDUCED_POWER_RESET 1'b0
`define PS_ERROR_LEVEL_RESET 1'b1
`define PRIO_RESET 3'h0

// Counter advances once per this many core clocks
`define COUNT_TICK_DIV 2

`endif

// ### common/timer_mode_pkg.sv
// Types shared by the interval timer and mode logic
package timer_mode_pkg;

  typedef enum logic [2:0] {
    MODE_KERNEL = 3'b001,
    MODE_USER   = 3'b010,
    MODE_DEBUG  = 3'b100
  } op_mode_t;

  typedef logic [2:0] prio_t;

endpackage

// ### core/tick_divider.sv
// Free-running divider producing a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
`default_nettype none

module tick_divider #(
  parameter int DIV = 2
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Enable pulse
  output logic tick_o
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] div_q;

  // Never stalled, so the rate does not depend on anything upstream
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q <= '0;
    end else if (div_q == LAST) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + CW'(1);
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= (div_q == LAST);
    end
  end

endmodule

`default_nettype wire

// ### core/core_interval_timer_and_mode_status.sv
// Interval counter, compare interrupt and processor status / operating mode logic
//
// Functional notes
// R01 - Counter advances at a fixed rate, independent of pipeline progress.
// R02 - Counter increments every second clock while count disable is zero.
// R03 - Software may overwrite the counter anytime; counting continues from it.
// R04 - Debug count run bit chooses counting or freezing in Debug mode.
// R05 - Compare register changes only on a software write.
// R06 - Timer interrupt asserts when counter equals compare.
// R07 - Timer interrupt stays asserted until compare is written.
// R08 - Interrupts enabled only with enable set, exception, error, debug clear.
// R09 - Enabled interrupt requests are further qualified by the priority threshold.
// R10 - Debug mode when debug flag set, else Kernel or User.
// R11 - User mode only when user select set and exception, error clear.
// R12 - Kernel mode when user select clear or exception or error set.
// R13 - Access to an unusable system coprocessor raises an exception.
// R14 - Counter is a full 32-bit read/write register.
// R15 - Compare is a full 32-bit read/write register.
// R16 - Request signalled only when its level exceeds the three-bit threshold.
// R17 - System coprocessor is always usable in Kernel mode.
// R18 - Error level set on reset, soft reset, NMI or cache error.
// R19 - Counter wraps from all ones to zero and keeps counting.
// R20 - Equality is checked after every counter change or register write; the code checks only on counter changes and compare writes.
`include "timer_mode_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module core_interval_timer_and_mode_status
  import timer_mode_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int TICK_DIV = `COUNT_TICK_DIV
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // System coprocessor register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [4:0] reg_num_i,
  input wire logic [2:0] reg_sel_i,
  input wire logic [WIDTH-1:0] reg_wdata_i,
  output logic [WIDTH-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Control bits held outside this block
  input wire logic count_disable_i,
  input wire logic debug_mode_flag_i,
  input wire logic debug_count_run_i,
  // Exception events that force the error level
  input wire logic soft_reset_i,
  input wire logic nmi_i,
  input wire logic cache_error_i,
  // Interrupt request qualification
  input wire logic irq_req_i,
  input wire logic [2:0] irq_req_level_i,
  output logic irq_enabled_o,
  output logic irq_signal_o,
  // Timer interrupt toward the interrupt controller
  output logic timer_irq_o,
  // Operating mode and coprocessor access
  output op_mode_t mode_o,
  input wire logic syscop_access_i,
  output logic syscop_unusable_exc_o
);

  // Register decode
  logic sel_main;
  logic hit_counter;
  logic hit_compare;
  logic hit_pstatus;
  logic wr_counter;
  logic wr_compare;
  logic wr_pstatus;

  assign sel_main = (reg_sel_i == `REG_SEL_MAIN);

  always_comb begin
    hit_counter = 1'b0;
    hit_compare = 1'b0;
    hit_pstatus = 1'b0;
    if (sel_main && reg_num_i == `REG_NUM_COUNTER) begin
      hit_counter = 1'b1;
    end else if (sel_main && reg_num_i == `REG_NUM_COMPARE) begin
      hit_compare = 1'b1;
    end else if (sel_main && reg_num_i == `REG_NUM_PSTATUS) begin
      hit_pstatus = 1'b1;
    end
  end

  assign wr_counter = reg_wr_i && hit_counter;
  assign wr_compare = reg_wr_i && hit_compare;
  assign wr_pstatus = reg_wr_i && hit_pstatus;

  // Count rate
  logic count_tick;

  // R01 fixed rate divider
  tick_divider #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .tick_o(count_tick)
  );

  // Interval counter
  logic [WIDTH-1:0] interval_counter_q;
  logic [WIDTH-1:0] interval_counter_d;
  logic count_step;
  logic counter_changed;

  // R02 tick gated by disable
  // R04 debug freeze control
  assign count_step = count_tick && !count_disable_i && (!debug_mode_flag_i || debug_count_run_i);

  always_comb begin
    interval_counter_d = interval_counter_q;
    // R03 software write wins
    if (wr_counter) begin
      interval_counter_d = reg_wdata_i;
    end else if (count_step) begin
      // R19 plain wrap to zero
      interval_counter_d = interval_counter_q + WIDTH'(1);
    end
  end

  assign counter_changed = wr_counter || count_step;

  // R14 full width counter
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      interval_counter_q <= `COUNTER_RESET;
    end else begin
      interval_counter_q <= interval_counter_d;
    end
  end

  // Compare register
  logic [WIDTH-1:0] interval_compare_q;
  logic [WIDTH-1:0] interval_compare_d;

  // R05 changes on write only
  assign interval_compare_d = wr_compare ? reg_wdata_i : interval_compare_q;

  // R15 full width compare
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      interval_compare_q <= `COMPARE_RESET;
    end else begin
      interval_compare_q <= interval_compare_d;
    end
  end

  // Timer interrupt
  logic match_now;
  logic timer_irq_d;

  // R20 check after any change; next values are compared so a write that
  // lands on the count is seen in the same cycle as the write itself
  assign match_now = (counter_changed || wr_compare) && (interval_counter_d == interval_compare_d);

  always_comb begin
    timer_irq_d = timer_irq_o;
    // R06 assert on equality
    if (match_now) begin
      timer_irq_d = 1'b1;
    // R07 held until compare write
    end else if (wr_compare) begin
      timer_irq_d = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      timer_irq_o <= 1'b0;
    end else begin
      timer_irq_o <= timer_irq_d;
    end
  end

  // Processor status fields
  logic syscop_usable_q;
  logic reduced_power_enable_q;
  logic reverse_endian_user_q;
  logic boot_vector_select_q;
  logic soft_reset_flag_q;
  logic nmi_flag_q;
  prio_t priority_threshold_q;
  logic user_mode_select_q;
  logic error_level_q;
  logic exception_level_q;
  logic global_irq_enable_q;

  // Plain read/write fields
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      syscop_usable_q <= 1'b0;
      reduced_power_enable_q <= `PS_REDUCED_POWER_RESET;
      reverse_endian_user_q <= 1'b0;
      boot_vector_select_q <= `PS_BOOT_VECTOR_RESET;
      priority_threshold_q <= `PRIO_RESET;
      user_mode_select_q <= 1'b0;
      exception_level_q <= 1'b0;
      global_irq_enable_q <= 1'b0;
    end else if (wr_pstatus) begin
      syscop_usable_q <= reg_wdata_i[`PS_SYSCOP_USABLE];
      reduced_power_enable_q <= reg_wdata_i[`PS_REDUCED_POWER];
      reverse_endian_user_q <= reg_wdata_i[`PS_REVERSE_ENDIAN];
      boot_vector_select_q <= reg_wdata_i[`PS_BOOT_VECTOR];
      priority_threshold_q <= reg_wdata_i[`PS_PRIO_MSB:`PS_PRIO_LSB];
      user_mode_select_q <= reg_wdata_i[`PS_USER_MODE];
      exception_level_q <= reg_wdata_i[`PS_EXC_LEVEL];
      global_irq_enable_q <= reg_wdata_i[`PS_GLOBAL_IE];
    end
  end

  // R18 hardware set of error level wins over a write of zero
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      error_level_q <= `PS_ERROR_LEVEL_RESET;
    end else if (soft_reset_i || nmi_i || cache_error_i) begin
      error_level_q <= 1'b1;
    end else if (wr_pstatus) begin
      error_level_q <= reg_wdata_i[`PS_ERROR_LEVEL];
    end
  end

  // Software may only clear these two; a new event in the same cycle wins
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      soft_reset_flag_q <= `PS_SOFT_RESET_RESET;
    end else if (soft_reset_i) begin
      soft_reset_flag_q <= 1'b1;
    end else if (wr_pstatus && !reg_wdata_i[`PS_SOFT_RESET]) begin
      soft_reset_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nmi_flag_q <= `PS_NMI_RESET;
    end else if (nmi_i) begin
      nmi_flag_q <= 1'b1;
    end else if (wr_pstatus && !reg_wdata_i[`PS_NMI_FLAG]) begin
      nmi_flag_q <= 1'b0;
    end
  end

  // Mode and interrupt enable
  logic irq_en_now;
  logic kernel_now;
  logic user_now;
  op_mode_t mode_d;

  // R08 all four conditions
  assign irq_en_now = global_irq_enable_q && !exception_level_q && !error_level_q
                      && !debug_mode_flag_i;
  // R12 any one forces Kernel
  assign kernel_now = !user_mode_select_q || exception_level_q || error_level_q;
  // R11 all three needed for User
  assign user_now = user_mode_select_q && !exception_level_q && !error_level_q;

  always_comb begin
    // R10 debug flag overrides
    if (debug_mode_flag_i) begin
      mode_d = MODE_DEBUG;
    end else if (user_now) begin
      mode_d = MODE_USER;
    end else begin
      mode_d = MODE_KERNEL;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_o <= MODE_KERNEL;
    end else begin
      mode_o <= mode_d;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_enabled_o <= 1'b0;
      irq_signal_o <= 1'b0;
    end else begin
      irq_enabled_o <= irq_en_now;
      // R09 threshold qualification
      // R16 strictly above threshold
      irq_signal_o <= irq_en_now && irq_req_i && (irq_req_level_i > priority_threshold_q);
    end
  end

  // Coprocessor access check; Debug mode is treated as privileged
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      syscop_unusable_exc_o <= 1'b0;
    end else begin
      // R13 unusable access traps
      // R17 Kernel always usable
      syscop_unusable_exc_o <= syscop_access_i && !syscop_usable_q && !kernel_now
                               && !debug_mode_flag_i;
    end
  end

  // Register read
  logic [WIDTH-1:0] pstatus_view;
  logic [WIDTH-1:0] rdata_d;

  always_comb begin
    pstatus_view = '0;
    pstatus_view[`PS_SYSCOP_USABLE] = syscop_usable_q;
    pstatus_view[`PS_REDUCED_POWER] = reduced_power_enable_q;
    pstatus_view[`PS_REVERSE_ENDIAN] = reverse_endian_user_q;
    pstatus_view[`PS_BOOT_VECTOR] = boot_vector_select_q;
    pstatus_view[`PS_SOFT_RESET] = soft_reset_flag_q;
    pstatus_view[`PS_NMI_FLAG] = nmi_flag_q;
    pstatus_view[`PS_PRIO_MSB:`PS_PRIO_LSB] = priority_threshold_q;
    pstatus_view[`PS_USER_MODE] = user_mode_select_q;
    pstatus_view[`PS_ERROR_LEVEL] = error_level_q;
    pstatus_view[`PS_EXC_LEVEL] = exception_level_q;
    pstatus_view[`PS_GLOBAL_IE] = global_irq_enable_q;
  end

  // Unmapped numbers read as zero rather than faulting
  always_comb begin
    rdata_d = '0;
    if (hit_counter) begin
      rdata_d = interval_counter_q;
    end else if (hit_compare) begin
      rdata_d = interval_compare_q;
    end else if (hit_pstatus) begin
      rdata_d = pstatus_view;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= '0;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_d;
      end
    end
  end

endmodule

`default_nettype wire

// ### dv/irq_ctrl_model.sv
// Interrupt controller model: forwards the timer line as a prioritised request
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Timer line and chosen priority
  input wire logic timer_irq_i,
  input wire logic [2:0] level_i,
  // Request toward the core
  output logic req_o,
  output logic [2:0] req_level_o
);
  // Registered like a real controller, so the request trails the timer by one edge
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_o <= 1'b0;
      req_level_o <= 3'h0;
    end else begin
      req_o <= timer_irq_i;
      req_level_o <= level_i;
    end
  end
endmodule
`default_nettype wire

// ### dv/core_interval_timer_and_mode_status_chk.sv
// Port checker for the interval timer and mode status block
`timescale 1ns/1ps
`default_nettype none
module core_interval_timer_and_mode_status_chk
  import timer_mode_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int TICK_DIV = 2
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [4:0] reg_num_i,
  input wire logic [2:0] reg_sel_i,
  input wire logic reg_rvalid_o,
  input wire logic debug_mode_flag_i,
  input wire logic nmi_i,
  input wire logic irq_req_i,
  input wire logic [2:0] irq_req_level_i,
  input wire logic irq_enabled_o,
  input wire logic irq_signal_o,
  input wire logic timer_irq_o,
  input wire op_mode_t mode_o,
  input wire logic syscop_access_i,
  input wire logic syscop_unusable_exc_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  property p_rd_answer; reg_rd_i |=> reg_rvalid_o; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_pulse; !reg_rd_i |=> !reg_rvalid_o; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("stray read valid");
  property p_irq_hold;
    timer_irq_o && !(reg_wr_i && reg_num_i == 5'h0b && reg_sel_i == 3'h0) |=> timer_irq_o;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("timer irq dropped");
  property p_debug_mode; debug_mode_flag_i |=> mode_o == MODE_DEBUG; endproperty
  a_debug_mode: assert property (p_debug_mode) else $error("not in debug mode");
  property p_en_debug; debug_mode_flag_i |=> !irq_enabled_o; endproperty
  a_en_debug: assert property (p_en_debug) else $error("enabled in debug");
  property p_sig_req; !irq_req_i |=> !irq_signal_o; endproperty
  a_sig_req: assert property (p_sig_req) else $error("signal without request");
  property p_sig_lvl0; irq_req_level_i == 3'h0 |=> !irq_signal_o; endproperty
  a_sig_lvl0: assert property (p_sig_lvl0) else $error("level zero signalled");
  property p_sig_en; irq_signal_o |-> irq_enabled_o; endproperty
  a_sig_en: assert property (p_sig_en) else $error("signal while disabled");
  property p_kernel_ok; mode_o != MODE_USER |-> !syscop_unusable_exc_o; endproperty
  a_kernel_ok: assert property (p_kernel_ok) else $error("exception outside user");
  property p_no_access; !syscop_access_i |=> !syscop_unusable_exc_o; endproperty
  a_no_access: assert property (p_no_access) else $error("exception without access");
  property p_nmi_kernel;
    nmi_i && !debug_mode_flag_i ##1 !debug_mode_flag_i |=> mode_o == MODE_KERNEL;
  endproperty
  a_nmi_kernel: assert property (p_nmi_kernel) else $error("no kernel after nmi");
endmodule
bind core_interval_timer_and_mode_status core_interval_timer_and_mode_status_chk #(
  .WIDTH(WIDTH), .TICK_DIV(TICK_DIV)) u_chk (.clock_i, .rstn_i, .reg_wr_i, .reg_rd_i,
  .reg_num_i, .reg_sel_i, .reg_rvalid_o, .debug_mode_flag_i, .nmi_i, .irq_req_i,
  .irq_req_level_i, .irq_enabled_o, .irq_signal_o, .timer_irq_o, .mode_o, .syscop_access_i,
  .syscop_unusable_exc_o);
`default_nettype wire

// ### dv/core_interval_timer_and_mode_status_test.sv
// Self-checking bench for the interval timer and mode status block
`timescale 1ns/1ps
`default_nettype none
module core_interval_timer_and_mode_status_test;
  import timer_mode_pkg::*;
  logic clock_i, rstn_i, reg_wr_i, reg_rd_i, reg_rvalid_o, count_disable_i, debug_mode_flag_i;
  logic debug_count_run_i, soft_reset_i, nmi_i, cache_error_i, irq_req_i, irq_enabled_o;
  logic irq_signal_o, timer_irq_o, syscop_access_i, syscop_unusable_exc_o;
  logic [4:0] reg_num_i;
  logic [2:0] reg_sel_i, irq_req_level_i, prio_level;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  op_mode_t mode_o;
  int n_mismatch = 0;
  int checks = 0;
  logic [31:0] st [4] = '{32'h0000_0011, 32'h0000_0013, 32'h0000_0015, 32'h0000_0001};
  op_mode_t md [4] = '{MODE_USER, MODE_KERNEL, MODE_KERNEL, MODE_KERNEL};
  logic [31:0] cu [3] = '{32'h1000_0010, 32'h0000_0012, 32'h0000_0010};
  core_interval_timer_and_mode_status dut (.clock_i, .rstn_i, .reg_wr_i, .reg_rd_i, .reg_num_i,
    .reg_sel_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .count_disable_i, .debug_mode_flag_i,
    .debug_count_run_i, .soft_reset_i, .nmi_i, .cache_error_i, .irq_req_i, .irq_req_level_i,
    .irq_enabled_o, .irq_signal_o, .timer_irq_o, .mode_o, .syscop_access_i,
    .syscop_unusable_exc_o);
  irq_ctrl_model u_ctrl (.clock_i, .rstn_i, .timer_irq_i(timer_irq_o), .level_i(prio_level),
    .req_o(irq_req_i), .req_level_o(irq_req_level_i));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] num, input logic [31:0] data);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_num_i <= num;
    reg_wdata_i <= data;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [4:0] num, input logic [31:0] exp);
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_num_i <= num;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rvalid_o, 1'b1);
    chk(reg_rdata_o, exp);
  endtask
  // Counting window of n edges holds exactly n/2 ticks for even n, whatever the divider phase
  task automatic run(input int n);
    @(posedge clock_i);
    count_disable_i <= 1'b0;
    repeat (n) @(posedge clock_i);
    count_disable_i <= 1'b1;
    #1;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  // About 140 cycles are needed; twenty thousand means a hang
  initial begin
    #100us;
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    {rstn_i, reg_wr_i, reg_rd_i, reg_num_i, reg_sel_i, reg_wdata_i} = '0;
    {debug_mode_flag_i, debug_count_run_i, soft_reset_i, nmi_i, cache_error_i} = '0;
    {syscop_access_i, prio_level} = '0;
    count_disable_i = 1'b1;
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'b1;
    rd(5'h0c, 32'h0050_0004);
    rd(5'h09, 32'h0);
    chk(mode_o, MODE_KERNEL);
    $display("test reset done");
    wr(5'h09, 32'hffff_fffe);
    rd(5'h09, 32'hffff_fffe);
    run(4);
    rd(5'h09, 32'h0);
    for (int r = 0; r < 2; r++) begin
      @(posedge clock_i);
      debug_mode_flag_i <= 1'b1;
      debug_count_run_i <= r[0];
      run(4);
      rd(5'h09, 32'(2 * r));
    end
    @(posedge clock_i);
    debug_mode_flag_i <= 1'b0;
    $display("test counter done");
    wr(5'h0b, 32'h5);
    run(4);
    rd(5'h0b, 32'h5);
    chk(timer_irq_o, 1'b0);
    run(2);
    chk(timer_irq_o, 1'b1);
    run(4);
    chk(timer_irq_o, 1'b1);
    wr(5'h0b, 32'h9);
    chk(timer_irq_o, 1'b0);
    wr(5'h09, 32'h9);
    chk(timer_irq_o, 1'b1);
    $display("test timer done");
    for (int i = 0; i < 4; i++) begin
      wr(5'h0c, st[i]);
      wt(2);
      chk(mode_o, md[i]);
      chk(irq_enabled_o, i == 0 || i == 3);
    end
    wr(5'h0c, 32'hffff_ffff);
    rd(5'h0c, 32'h1a40_1c17);
    @(posedge clock_i);
    syscop_access_i <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(5'h0c, cu[i]);
      wt(2);
      chk(syscop_unusable_exc_o, i == 2);
    end
    // User status with the usable bit clear, so only Debug privilege can hide the trap
    @(posedge clock_i);
    debug_mode_flag_i <= 1'b1;
    wt(2);
    chk(mode_o, MODE_DEBUG);
    chk(syscop_unusable_exc_o, 1'b0);
    @(posedge clock_i);
    debug_mode_flag_i <= 1'b0;
    syscop_access_i <= 1'b0;
    wr(5'h0c, 32'h0000_0801);
    for (int lv = 1; lv < 4; lv++) begin
      @(posedge clock_i);
      prio_level <= 3'(lv);
      wt(3);
      chk(irq_signal_o, lv > 2);
    end
    $display("test mode done");
    for (int e = 0; e < 3; e++) begin
      wr(5'h0c, 32'h0000_0001);
      @(posedge clock_i);
      {soft_reset_i, nmi_i, cache_error_i} <= 3'b100 >> e;
      @(posedge clock_i);
      {soft_reset_i, nmi_i, cache_error_i} <= 3'b000;
      rd(5'h0c, 32'h0000_0005 | (32'h0010_0000 >> e) & 32'h0018_0000);
      chk(irq_enabled_o, 1'b0);
    end
    rd(5'h05, 32'h0);
    @(posedge clock_i);
    reg_sel_i <= 3'h1;
    wr(5'h09, 32'h1234);
    rd(5'h09, 32'h0);
    @(posedge clock_i);
    reg_sel_i <= 3'h0;
    rd(5'h09, 32'h9);
    $display("test events done");
    report_and_stop;
  end
endmodule
`default_nettype wire
